// ### core/ccsg_pkg.sv
// Constants, register map and state type of the core supply guard.
// Summary of operation
// - Enable core supply only after power-good.
// - Disable core supply when power-good drops.
// - Thermal trip turns supply off within 0.5 s.
// - Compare five-bit voltage codes of installed processors.
// - Code mismatch disables every regulator output.
// - Empty socket code never counts as mismatch.
// - Embedded regulator: empty socket adjusts load line.
// - Socket-occupied pin may decide processor presence.
package ccsg_pkg;
	localparam int          VID_W          = 5;
	localparam logic [4:0]  VID_EMPTY      = 5'h1F;
	localparam int          N_SOCK_DEF     = 2;
	localparam int          APB_AW         = 8;
	// Thermal trip response bound, in milliseconds, and the clock rate
	localparam int          TRIP_LIMIT_MS  = 500;
	localparam int          CLK_KHZ        = 100000;
	localparam int          TRIP_LIMIT_CYC = TRIP_LIMIT_MS * CLK_KHZ;
	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_STATUS     = 8'h04;
	localparam logic [7:0]  OFS_IRQ_STAT   = 8'h08;
	localparam logic [7:0]  OFS_IRQ_MASK   = 8'h0C;
	localparam logic [7:0]  OFS_VID        = 8'h10;
	// Control fields
	localparam int          CTRL_ENABLE    = 0;
	localparam int          CTRL_EMBEDDED  = 1;
	localparam int          CTRL_USE_OCC   = 2;
	localparam logic [2:0]  CTRL_RST       = 3'h1;
	// Status fields
	localparam int          STS_STATE      = 0;
	localparam int          STS_MISMATCH   = 2;
	localparam int          STS_TRIP       = 3;
	localparam int          STS_PG         = 4;
	localparam int          STS_LOADLINE   = 5;
	localparam int          STS_PRESENT    = 8;
	localparam int          STS_ENABLE     = 16;
	// Interrupt status and mask fields
	localparam int          IRQ_W          = 4;
	localparam int          IRQ_TRIP       = 0;
	localparam int          IRQ_MISMATCH   = 1;
	localparam int          IRQ_PG_LOST    = 2;
	localparam int          IRQ_POWER_UP   = 3;
	localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;
	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_ON    = 2'b01,
		ST_FAULT = 2'b11
	} ccsg_state_t;
endpackage : ccsg_pkg

// ### core/ccsg_vid_if.sv
// Bundle between the guard core and the voltage-code comparator.
interface ccsg_vid_if #(parameter int N_SOCK = 2);
	logic [N_SOCK-1:0][4:0] vid;
	logic [N_SOCK-1:0]      occ_n;
	logic                   use_occ;
	logic [N_SOCK-1:0]      present;
	logic                   mismatch;
	logic [4:0]             common_vid;
	modport cmp (input vid, input occ_n, input use_occ,
		output present, output mismatch, output common_vid);
	modport ctl (output vid, output occ_n, output use_occ,
		input present, input mismatch, input common_vid);
endinterface : ccsg_vid_if

// ### core/ccsg_sync.sv
// Two-stage synchroniser with clock enable and constant reset level.
module ccsg_sync #(
	parameter int              W       = 1,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic          clk_en,
	input  wire logic [W-1:0]  d,
	output logic      [W-1:0]  q
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end
		else if (clk_en)
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

	a_sync_two_stage: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en ##1 clk_en |=> q == $past(d, 2))
		else $error("synchroniser output is not the input two cycles back");
endmodule : ccsg_sync

// ### core/ccsg_vid_cmp.sv
// Presence detection and voltage-code agreement across sockets.
module ccsg_vid_cmp #(parameter int N_SOCK = 2) (
	ccsg_vid_if.cmp vi
);
	import ccsg_pkg::*;

	logic [N_SOCK-1:0][N_SOCK-1:0] pair_mm;
	logic [N_SOCK:0][4:0]          ref_chain;

	assign ref_chain[N_SOCK] = VID_EMPTY;

	// Presence by pin or by code; code of lowest present socket is reported
	for (genvar i = 0; i < N_SOCK; i++)
	begin : g_sock
		assign vi.present[i] = vi.use_occ ? !vi.occ_n[i] : (vi.vid[i] != VID_EMPTY);
		assign ref_chain[i]  = vi.present[i] ? vi.vid[i] : ref_chain[i+1];
		for (genvar j = 0; j < N_SOCK; j++)
		begin : g_pair
			// Only installed pairs count, so an empty socket never trips it
			assign pair_mm[i][j] = (j > i) && vi.present[i] && vi.present[j]
				&& (vi.vid[i] != vi.vid[j]);
		end
	end

	assign vi.mismatch   = |pair_mm;
	assign vi.common_vid = ref_chain[0];
endmodule : ccsg_vid_cmp

// ### core/ccsg_top.sv
// Core supply guard: power-good tracking, trip and code-mismatch shutdown.
//
// Decided for this implementation: register access over APB and the placing of the registers.
module ccsg_top #(
	parameter int N_SOCK         = ccsg_pkg::N_SOCK_DEF,
	parameter int TRIP_LIMIT_CYC = ccsg_pkg::TRIP_LIMIT_CYC
) (
	input  wire logic                                     clk_sys,
	input  wire logic                                     rst_n,
	input  wire logic                                     clk_en,
	input  wire logic                                     psel,
	input  wire logic                                     penable,
	input  wire logic                                     pwrite,
	input  wire logic [ccsg_pkg::APB_AW-1:0]              paddr,
	input  wire logic [31:0]                              pwdata,
	output logic      [31:0]                              prdata,
	output logic                                          pready,
	output logic                                          pslverr,
	input  wire logic                                     system_stable_ind,
	input  wire logic [N_SOCK-1:0]                        thermal_trip_n,
	input  wire logic [N_SOCK-1:0]                        socket_occupied_n,
	input  wire logic [N_SOCK-1:0][ccsg_pkg::VID_W-1:0]   voltage_id_code,
	output logic      [N_SOCK-1:0]                        regulator_output_enable,
	output logic                                          loadline_adjust,
	output logic                                          irq
);
	import ccsg_pkg::*;

	// Status layout keeps presence and enable bits in one byte each
	if (N_SOCK < 1 || N_SOCK > 8)
	begin : g_bad_sock
		$error("N_SOCK must be 1 to 8");
	end
	if (TRIP_LIMIT_CYC < 8)
	begin : g_bad_limit
		$error("TRIP_LIMIT_CYC too small for the response path");
	end

	ccsg_vid_if #(.N_SOCK(N_SOCK)) vi ();

	logic                          pg_s;
	logic [N_SOCK-1:0]             trip_n_s;
	logic [N_SOCK-1:0]             occ_n_s;
	logic [N_SOCK-1:0][4:0]        vid_s;
	ccsg_state_t                   state_q;
	ccsg_state_t                   state_d;
	logic [2:0]                    ctrl_q;
	logic [IRQ_W-1:0]              irq_stat_q;
	logic [IRQ_W-1:0]              irq_stat_d;
	logic [IRQ_W-1:0]              irq_mask_q;
	logic [N_SOCK-1:0]             en_d;

	// Every board input is resynchronised before any decision
	ccsg_sync #(.W(1), .RST_VAL(1'b0)) u_sync_pg (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.d       (system_stable_ind),
		.q       (pg_s)
	);
	ccsg_sync #(.W(N_SOCK), .RST_VAL({N_SOCK{1'b1}})) u_sync_trip (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.d       (thermal_trip_n),
		.q       (trip_n_s)
	);
	ccsg_sync #(.W(N_SOCK), .RST_VAL({N_SOCK{1'b1}})) u_sync_occ (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.d       (socket_occupied_n),
		.q       (occ_n_s)
	);
	ccsg_sync #(.W(N_SOCK * 5), .RST_VAL({(N_SOCK * 5){1'b1}})) u_sync_vid (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.d       (voltage_id_code),
		.q       (vid_s)
	);

	assign vi.vid     = vid_s;
	assign vi.occ_n   = occ_n_s;
	assign vi.use_occ = ctrl_q[CTRL_USE_OCC];

	ccsg_vid_cmp #(.N_SOCK(N_SOCK)) u_cmp (
		.vi (vi.cmp)
	);

	// Fault conditions seen by the sequencer
	wire trip_any    = !(&trip_n_s);
	wire mismatch    = vi.mismatch;
	wire any_present = |vi.present;
	wire any_absent  = !(&vi.present);
	wire embedded    = ctrl_q[CTRL_EMBEDDED];
	wire sw_enable   = ctrl_q[CTRL_ENABLE];
	wire fault_now   = trip_any || mismatch;
	wire may_power   = pg_s && sw_enable && any_present && !fault_now;

	// Sequencer: power-good loss wins over every other condition
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_OFF:
				if (may_power)
					state_d = ST_ON;
			ST_ON:
				if (!pg_s)
					state_d = ST_OFF;
				else if (fault_now)
					state_d = ST_FAULT;
				else if (!sw_enable)
					state_d = ST_OFF;
			ST_FAULT:
				if (!pg_s)
					state_d = ST_OFF;
			default:
				state_d = ST_OFF;
		endcase
	end

	// Per-module regulators of empty sockets stay off; embedded one is shared
	assign en_d = (state_d == ST_ON)
		? (embedded ? {N_SOCK{1'b1}} : vi.present)
		: '0;

	// Sequencer state and regulator enables, registered toward the pins
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q                 <= ST_OFF;
			regulator_output_enable <= '0;
			loadline_adjust         <= 1'b0;
		end
		else if (clk_en)
		begin
			state_q                 <= state_d;
			regulator_output_enable <= en_d;
			loadline_adjust         <= embedded && any_absent && any_present;
		end
	end

	// Events recorded for software
	logic [IRQ_W-1:0] evt;
	assign evt[IRQ_TRIP]     = (state_q == ST_ON) && (state_d == ST_FAULT) && trip_any;
	assign evt[IRQ_MISMATCH] = (state_q == ST_ON) && (state_d == ST_FAULT) && mismatch;
	assign evt[IRQ_PG_LOST]  = (state_q != ST_OFF) && !pg_s;
	assign evt[IRQ_POWER_UP] = (state_q == ST_OFF) && (state_d == ST_ON);

	// APB decode: no wait cycle; read data is captured in a flip-flop during the setup cycle
	wire setup      = psel && !penable && !pready;
	wire access     = psel && penable && pready;
	wire hit_ctrl   = (paddr == OFS_CTRL);
	wire hit_status = (paddr == OFS_STATUS);
	wire hit_istat  = (paddr == OFS_IRQ_STAT);
	wire hit_imask  = (paddr == OFS_IRQ_MASK);
	wire hit_vid    = (paddr == OFS_VID);
	wire hit_any    = hit_ctrl || hit_status || hit_istat || hit_imask || hit_vid;
	wire wr_ctrl    = access && pwrite && hit_ctrl;
	wire wr_imask   = access && pwrite && hit_imask;
	wire rd_istat   = access && !pwrite && hit_istat;

	logic [31:0] status_word;
	logic [31:0] rd_mux;
	always_comb
	begin
		status_word = '0;
		status_word[STS_STATE +: 2]          = state_q;
		status_word[STS_MISMATCH]            = mismatch;
		status_word[STS_TRIP]                = trip_any;
		status_word[STS_PG]                  = pg_s;
		status_word[STS_LOADLINE]            = loadline_adjust;
		status_word[STS_PRESENT +: N_SOCK]   = vi.present;
		status_word[STS_ENABLE +: N_SOCK]    = regulator_output_enable;
	end
	assign rd_mux = hit_ctrl   ? {29'h0, ctrl_q}
		: hit_status ? status_word
		: hit_istat  ? {28'h0, irq_stat_q}
		: hit_imask  ? {28'h0, irq_mask_q}
		: hit_vid    ? {27'h0, vi.common_vid}
		: 32'h0;

	// Read clears only the bits that were returned; a new event still sets
	assign irq_stat_d = (irq_stat_q & ~(rd_istat ? prdata[IRQ_W-1:0] : '0)) | evt;

	// APB answer flops
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end
		else if (clk_en)
		begin
			pready  <= setup;
			pslverr <= setup && !hit_any;
			prdata  <= setup ? rd_mux : prdata;
		end
	end

	// Software registers and interrupt line
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q     <= CTRL_RST;
			irq_mask_q <= IRQ_MASK_RST;
			irq_stat_q <= '0;
			irq        <= 1'b0;
		end
		else if (clk_en)
		begin
			ctrl_q     <= wr_ctrl ? pwdata[2:0] : ctrl_q;
			irq_mask_q <= wr_imask ? pwdata[IRQ_W-1:0] : irq_mask_q;
			irq_stat_q <= irq_stat_d;
			irq        <= |(irq_stat_d & irq_mask_q);
		end
	end

	// Helper: enabled cycles since a raw trip was seen with supply on
	logic [31:0] trip_age_q;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			trip_age_q <= 32'h0;
		else if (!clk_en)
			trip_age_q <= trip_age_q; // Frozen with the rest of the state
		else if (!(&thermal_trip_n) && (|regulator_output_enable))
			trip_age_q <= trip_age_q + 32'h1;
		else
			trip_age_q <= 32'h0;
	end

	a_on_needs_pg: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(|regulator_output_enable) |-> $past(pg_s))
		else $error("regulator enabled without power-good");

	a_pg_loss_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && !pg_s |=> regulator_output_enable == '0 && state_q == ST_OFF)
		else $error("regulators still on after power-good loss");

	a_trip_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
		trip_age_q < TRIP_LIMIT_CYC)
		else $error("thermal trip not honoured in time");

	a_trip_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && state_q == ST_ON && pg_s && trip_any |=> state_q == ST_FAULT)
		else $error("trip did not latch a fault");

	a_mismatch_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && mismatch |=> regulator_output_enable == '0)
		else $error("regulators on despite code mismatch");

	a_empty_keeps_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && state_q == ST_ON && pg_s && sw_enable && !trip_any && !mismatch
		|=> state_q == ST_ON)
		else $error("supply dropped without cause");

	a_embedded_loadline: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && embedded && any_absent && any_present |=> loadline_adjust)
		else $error("load line not adjusted for empty socket");

	a_fault_latched: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == ST_FAULT && !(clk_en && !pg_s) |=> state_q == ST_FAULT)
		else $error("fault released without power-good cycle");

	a_occ_presence: assert property (@(posedge clk_sys) disable iff (!rst_n)
		vi.use_occ |-> vi.present == ~occ_n_s)
		else $error("presence does not follow socket-occupied pins");

	a_mismatch_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(&vi.present) && (vid_s[0] != vid_s[N_SOCK-1]) |-> mismatch)
		else $error("differing codes of installed processors missed");

	// Output-side guards: an enable that escapes the state or presence, a load line without embedded regulator, a wrong reported code
	a_off_no_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == ST_OFF |-> regulator_output_enable == '0)
		else $error("regulator enabled while sequencer is off");

	a_fault_no_power: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == ST_FAULT |-> regulator_output_enable == '0)
		else $error("regulator enabled while fault is latched");

	a_empty_stays_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && !embedded |=> (regulator_output_enable & ~$past(vi.present)) == '0)
		else $error("regulator of an empty socket enabled");

	a_loadline_embedded: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && !embedded |=> !loadline_adjust)
		else $error("load line adjusted without embedded regulator");

	a_vid_common: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!mismatch && vi.present[0] |-> vi.common_vid == vid_s[0])
		else $error("reported code differs from installed processor");

	c_power_up: cover property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(|regulator_output_enable));
	c_trip_fault: cover property (@(posedge clk_sys) disable iff (!rst_n)
		evt[IRQ_TRIP]);
	c_mismatch_fault: cover property (@(posedge clk_sys) disable iff (!rst_n)
		evt[IRQ_MISMATCH]);
	c_irq_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
		irq ##[1:20] rd_istat);
endmodule : ccsg_top

// ### dv/ccsg_board_model.sv
// Behavioural model of the supply board and the two processor sockets.
module ccsg_board_model #(
	parameter int STABLE_DLY = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             rails_ok,
	input  wire logic             float_vid,
	input  wire logic [1:0]       present,
	input  wire logic [1:0]       trip_req,
	input  wire logic [1:0][4:0]  vid_req,
	output logic                  system_stable_ind,
	output logic      [1:0]       thermal_trip_n,
	output logic      [1:0]       socket_occupied_n,
	output logic      [1:0][4:0]  voltage_id_code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q;

	// Settle counter restarts whenever any rail falls out of range
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= 8'h00;
		else if (!rails_ok)
			cnt_q <= 8'h00;
		else if (cnt_q < 8'(STABLE_DLY))
			cnt_q <= cnt_q + 8'h01;
	end

	// Flag rises late but falls at once, with no filtering on the way down
	assign system_stable_ind = rails_ok && (cnt_q == 8'(STABLE_DLY));

	// Empty sockets float their code high; float_vid breaks that on purpose
	for (genvar g = 0; g < 2; g++)
	begin : g_sock
		assign socket_occupied_n[g] = ~present[g];
		assign voltage_id_code[g] = (present[g] || float_vid) ? vid_req[g] : 5'h1F;
		assign thermal_trip_n[g] = ~(present[g] && trip_req[g]);
	end
endmodule : ccsg_board_model

// ### dv/ccsg_bench.sv
// Self-checking bench of the core supply guard.
module ccsg_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ccsg_pkg::*;
	logic             clk_sys, rst_n, psel, penable, pwrite, rails_ok, float_vid;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, r;
	logic             pready, pslverr, loadline_adjust, irq, e, system_stable_ind, clk_en;
	logic [1:0]       thermal_trip_n, socket_occupied_n, regulator_output_enable;
	logic [1:0]       present, trip_req;
	logic [1:0][4:0]  voltage_id_code, vid_req;
	logic [4:0]       v;
	int               mismatches, samples_checked;

	always #5 clk_sys = ~clk_sys;

	ccsg_top #(.N_SOCK(2), .TRIP_LIMIT_CYC(64)) i_ccsg_top (.clk_sys(clk_sys), .rst_n(rst_n),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.system_stable_ind(system_stable_ind), .thermal_trip_n(thermal_trip_n),
		.socket_occupied_n(socket_occupied_n), .voltage_id_code(voltage_id_code),
		.regulator_output_enable(regulator_output_enable),
		.loadline_adjust(loadline_adjust), .irq(irq));
	ccsg_board_model #(.STABLE_DLY(16)) i_ccsg_board_model (.clk_sys(clk_sys), .rst_n(rst_n),
		.rails_ok(rails_ok), .float_vid(float_vid), .present(present), .trip_req(trip_req),
		.vid_req(vid_req), .system_stable_ind(system_stable_ind),
		.thermal_trip_n(thermal_trip_n), .socket_occupied_n(socket_occupied_n),
		.voltage_id_code(voltage_id_code));

	// Enables expected from presence; the embedded regulator drives all outputs alike
	function automatic logic [1:0] exp_en(input logic [1:0] pres, input logic emb);
		return emb ? {2{|pres}} : pres;
	endfunction : exp_en

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] act, input logic [31:0] x);
		samples_checked++;
		if (act !== x)
		begin
			mismatches++;
			$display("mismatch at %0t got %h expected %h", $time, act, x);
		end
	endtask : chk

	// One transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			mismatches++;
			end_sim();
		end
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r & m, x);
	endtask : rd

	// Bounded wait for the enables, then a compare either way
	task automatic wait_en(input logic [1:0] x);
		for (int n = 0; n < 64; n++)
		begin
			@(posedge clk_sys);
			#1;
			if (regulator_output_enable === x)
				break;
		end
		chk({30'h0, regulator_output_enable}, {30'h0, x});
		// A wait that ran out ends the run at once
		if (regulator_output_enable !== x)
			end_sim();
	endtask : wait_en

	task automatic hold_chk(input int cyc, input logic [1:0] x);
		repeat (cyc) @(posedge clk_sys);
		#1;
		chk({30'h0, regulator_output_enable}, {30'h0, x});
	endtask : hold_chk

	task automatic cycle_pg;
		@(posedge clk_sys);
		rails_ok <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rails_ok <= 1'b1;
	endtask : cycle_pg

	initial
	begin
		{clk_sys, rst_n, psel, penable, pwrite, rails_ok, float_vid} = 7'h00;
		{paddr, pwdata, trip_req} = '0;
		clk_en = 1'b1;
		void'($urandom(32'h2b93e142));
		v = 5'($urandom_range(29, 0));
		vid_req = {v, v};
		present = 2'b11;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(OFS_CTRL, 32'hFFFFFFFF, 32'h1);
		rd(OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
		apb(1'b0, 8'hFC, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test registers done");
		// Power-up only once the supply flag is up
		hold_chk(6, 2'b00);
		@(posedge clk_sys);
		rails_ok <= 1'b1;
		hold_chk(10, 2'b00);
		wait_en(2'b11);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, OFS_IRQ_MASK, 32'hF);
		hold_chk(2, 2'b11);
		chk({31'h0, irq}, 32'h1);
		rd(OFS_IRQ_STAT, 32'h8, 32'h8);
		hold_chk(2, 2'b11);
		chk({31'h0, irq}, 32'h0);
		rd(OFS_VID, 32'h1F, {27'h0, v});
		rd(OFS_STATUS, 32'hFFFFFFFF, 32'h00030311);
		$display("test power up done");
		// Loss of the flag: two sync edges, then the outputs drop
		@(posedge clk_sys);
		rails_ok <= 1'b0;
		hold_chk(2, 2'b11);
		hold_chk(1, 2'b00);
		rd(OFS_IRQ_STAT, 32'h4, 32'h4);
		$display("test power loss done");
		// Trip latches off until the flag cycles
		cycle_pg();
		wait_en(2'b11);
		@(posedge clk_sys);
		trip_req <= 2'b10;
		wait_en(2'b00);
		rd(OFS_IRQ_STAT, 32'h1, 32'h1);
		rd(OFS_STATUS, 32'hFFFFFFFF, 32'h0000031B);
		trip_req <= 2'b00;
		hold_chk(20, 2'b00);
		cycle_pg();
		wait_en(2'b11);
		$display("test trip done");
		// Code mismatch between installed processors
		@(posedge clk_sys);
		vid_req[1] <= v ^ 5'h01;
		wait_en(2'b00);
		rd(OFS_IRQ_STAT, 32'h2, 32'h2);
		vid_req[1] <= v;
		hold_chk(20, 2'b00);
		$display("test mismatch done");
		// Empty socket is no mismatch; its regulator stays off
		@(posedge clk_sys);
		present <= 2'b01;
		cycle_pg();
		wait_en(exp_en(2'b01, 1'b0));
		rd(OFS_IRQ_STAT, 32'h2, 32'h0);
		chk({31'h0, loadline_adjust}, 32'h0);
		$display("test empty socket done");
		// Embedded regulator adjusts its load line instead
		@(posedge clk_sys);
		rails_ok <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h3);
		cycle_pg();
		wait_en(exp_en(2'b01, 1'b1));
		chk({31'h0, loadline_adjust}, 32'h1);
		$display("test embedded done");
		// Presence from the occupied pin ignores a floating code
		@(posedge clk_sys);
		rails_ok <= 1'b0;
		float_vid <= 1'b1;
		vid_req[1] <= v ^ 5'h01;
		apb(1'b1, OFS_CTRL, 32'h5);
		cycle_pg();
		wait_en(exp_en(2'b01, 1'b0));
		rd(OFS_IRQ_STAT, 32'h2, 32'h0);
		chk({31'h0, loadline_adjust}, 32'h0);
		$display("test occupied pin done");
		// Clock enable low freezes the guard although the flag falls
		@(posedge clk_sys);
		clk_en <= 1'b0;
		rails_ok <= 1'b0;
		hold_chk(8, 2'b01);
		@(posedge clk_sys);
		clk_en <= 1'b1;
		hold_chk(2, 2'b01);
		hold_chk(1, 2'b00);
		$display("test clock enable done");
		end_sim();
	end
endmodule : ccsg_bench
